// >>> see_pkg.sv
// shared constants for the two-wire serial eeprom slave and its bus master
package see_pkg;
  // array organisation
  localparam int MEM_BYTES  = 2048;
  localparam int PAGE_BYTES = 16;
  localparam int ADDR_W     = 11;
  localparam int PAGE_W     = 4;
  localparam int BLK_W      = 3;
  localparam int BYTE_W     = 8;

  // control byte layout and bit counter marks
  localparam logic [3:0] CTRL_PATTERN = 4'hA;
  localparam logic       RW_READ      = 1'h1;
  localparam logic       RW_WRITE     = 1'h0;
  localparam logic [3:0] BIT_ACK      = 4'h8;
  localparam logic [3:0] BIT_DONE     = 4'h9;

  // device timing, counted on the link clock
  localparam int LINK_PERIOD_NS = 160;
  localparam int WRITE_TIME_NS  = 5_000_000;
  // a longest time rounds down
  localparam int WRITE_CYC      = WRITE_TIME_NS / LINK_PERIOD_NS;

  // master timing, counted on clk_in
  localparam int CLK_PERIOD_NS  = 50;
  localparam int SCL_MAX_HZ     = 1_000_000;
  localparam int SCL_DEF_HZ     = 250_000;
  localparam int NS_PER_S       = 1_000_000_000;
  localparam int QUARTERS       = 4;
endpackage

// >>> see_link_if.sv
// two-wire link between bus master and eeprom slave, with pull-up resolution
`timescale 1ns/1ps
interface see_link_if;
  logic scl;
  logic m_sda_o;
  logic m_sda_oe_n;
  logic d_sda_o;
  logic d_sda_oe_n;
  logic sda;

  // open-drain wire: low if any enabled driver pulls low, else the pull-up wins
  assign sda = !((!m_sda_oe_n && !m_sda_o) || (!d_sda_oe_n && !d_sda_o));

  modport master (output scl, output m_sda_o, output m_sda_oe_n, input sda);
  modport device (input scl, input sda, output d_sda_o, output d_sda_oe_n);
endinterface

// >>> see_eeprom_dev.sv
// two-wire serial eeprom slave: 2048 x 8 array, 16-byte page writes
`timescale 1ns/1ps
module see_eeprom_dev
  import see_pkg::*;
#(
  parameter int WRITE_CYCLES = WRITE_CYC
)
(
  // link clock and power-on reset
  input  wire logic link_clk_in,
  input  wire logic sys_rst_in,
  // two-wire bus
  see_link_if.device bus,
  // straps and protection
  input  wire logic wp_in,
  input  wire logic strap_select_bit0_in,
  input  wire logic strap_select_bit1_in,
  input  wire logic strap_select_bit2_in,
  // status
  output logic      standby_out,
  output logic      busy_out
);
  localparam int TMR_W = $clog2(WRITE_CYCLES + 1);

  typedef enum logic [2:0] {D_IDLE, D_CTRL, D_ADDR, D_WDATA, D_READ} see_dev_state_t;

  // array and page buffer
  logic [BYTE_W-1:0]     mem  [MEM_BYTES];
  logic [BYTE_W-1:0]     pbuf [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] pvalid;

  // pin sampling: bit 2 write-protect, bit 1 clock, bit 0 data
  logic [2:0]            pin_raw;
  logic [2:0]            sync1;
  logic [2:0]            sync2;
  logic [2:0]            sync3;
  logic [2:0]            filt;
  logic [2:0]            filt_d;
  logic [2:0]            agree;

  see_dev_state_t        state;
  logic [3:0]            bit_cnt;
  logic [BYTE_W-1:0]     shreg;
  logic [ADDR_W-1:0]     ptr;
  logic [BLK_W-1:0]      blk;
  logic [ADDR_W-PAGE_W-1:0] page;
  logic                  mack;
  logic                  sda_oe_n;
  logic                  busy;
  logic [TMR_W-1:0]      timer;
  logic [PAGE_W:0]       prog_idx;

  // straps are not bonded on this part; they are deliberately left unread
  logic [2:0]            strap_unused;
  assign strap_unused = {strap_select_bit2_in, strap_select_bit1_in, strap_select_bit0_in};

  // the clock line is only ever read; nothing here can drive it
  assign pin_raw = {wp_in, bus.scl, bus.sda};
  assign agree   = ~(sync2 ^ sync3);

  wire wp_f      = filt[2];
  wire scl_f     = filt[1];
  wire sda_f     = filt[0];
  wire scl_rise  = scl_f & ~filt_d[1];
  wire scl_fall  = ~scl_f & filt_d[1];
  wire start_ev  = scl_f & filt_d[1] & ~sda_f & filt_d[0];
  wire stop_ev   = scl_f & filt_d[1] & sda_f & ~filt_d[0];
  wire active    = (state != D_IDLE);
  wire ack_slot  = active & scl_fall & (bit_cnt == BIT_ACK);
  wire ctrl_hit  = (shreg[7:4] == CTRL_PATTERN) & ~busy;
  wire buf_we    = ack_slot & (state == D_WDATA);
  wire prog_we   = busy & ~prog_idx[PAGE_W] & pvalid[prog_idx[PAGE_W-1:0]];
  wire commit    = stop_ev & (state == D_WDATA) & (|pvalid);
  wire [BYTE_W-1:0] mem_q = mem[ptr];
  wire [PAGE_W-1:0] ptr_lo_inc = ptr[PAGE_W-1:0] + 4'h1;

  // open drain: the output value is always low, only the enable moves
  assign bus.d_sda_o    = 1'b0;
  assign bus.d_sda_oe_n = sda_oe_n;

  // three flops then a filter that only follows a line once two samples agree;
  // a single-sample glitch never reaches the start/stop detector
  always_ff @(posedge link_clk_in) begin
    if (sys_rst_in) begin
      sync1  <= 3'h3;
      sync2  <= 3'h3;
      sync3  <= 3'h3;
      filt   <= 3'h3;
      filt_d <= 3'h3;
    end else begin
      sync1  <= pin_raw;
      sync2  <= sync1;
      sync3  <= sync2;
      filt   <= (filt & ~agree) | (sync3 & agree);
      filt_d <= filt;
    end
  end

  // page buffer fill; more than sixteen bytes overwrite earlier ones
  always_ff @(posedge link_clk_in) begin
    if (buf_we) begin
      pbuf[ptr[PAGE_W-1:0]] <= shreg;
    end
  end

  // programming walks the page one byte per cycle, untouched bytes keep old data
  always_ff @(posedge link_clk_in) begin
    if (prog_we) begin
      mem[{page, prog_idx[PAGE_W-1:0]}] <= pbuf[prog_idx[PAGE_W-1:0]];
    end
  end

  always_ff @(posedge link_clk_in) begin
    if (sys_rst_in) begin
      state       <= D_IDLE;
      bit_cnt     <= 4'h0;
      shreg       <= 8'h00;
      ptr         <= 11'h000;
      blk         <= 3'h0;
      page        <= 7'h00;
      mack        <= 1'b0;
      sda_oe_n    <= 1'b1;
      busy        <= 1'b0;
      timer       <= '0;
      prog_idx    <= 5'h00;
      pvalid      <= 16'h0000;
      standby_out <= 1'b1;
      busy_out    <= 1'b0;
    end else begin
      standby_out <= (state == D_IDLE) & ~busy;
      busy_out    <= busy;
      // self-timed cycle; only reset can cut it short
      if (busy) begin
        timer <= timer - 1'b1;
        if (!prog_idx[PAGE_W]) begin
          prog_idx <= prog_idx + 5'h01;
        end
        if (timer == '0) begin
          busy   <= 1'b0;
          pvalid <= 16'h0000;
        end
      end
      if (start_ev) begin
        state    <= D_CTRL;
        bit_cnt  <= 4'h0;
        sda_oe_n <= 1'b1;
      end else if (stop_ev) begin
        state    <= D_IDLE;
        sda_oe_n <= 1'b1;
        if (commit && !wp_f) begin
          busy     <= 1'b1;
          timer    <= TMR_W'(WRITE_CYCLES - 1);
          prog_idx <= 5'h00;
          page     <= ptr[ADDR_W-1:PAGE_W];
        end else if (commit) begin
          pvalid   <= 16'h0000;
        end
      end else if (active && scl_rise) begin
        if (bit_cnt < BIT_ACK) begin
          shreg   <= {shreg[BYTE_W-2:0], sda_f};
          bit_cnt <= bit_cnt + 4'h1;
        end else if (bit_cnt == BIT_ACK) begin
          bit_cnt <= BIT_DONE;
          mack    <= sda_f;
        end
      end else if (ack_slot) begin
        case (state)
          D_CTRL: begin
            if (ctrl_hit) begin
              sda_oe_n <= 1'b0;
              blk      <= shreg[3:1];
              mack     <= 1'b0;
              state    <= (shreg[0] == RW_READ) ? D_READ : D_ADDR;
            end else begin
              state    <= D_IDLE;
            end
          end
          D_ADDR: begin
            ptr      <= {blk, shreg};
            pvalid   <= 16'h0000;
            sda_oe_n <= 1'b0;
            state    <= D_WDATA;
          end
          D_WDATA: begin
            pvalid[ptr[PAGE_W-1:0]] <= 1'b1;
            ptr      <= {ptr[ADDR_W-1:PAGE_W], ptr_lo_inc};
            sda_oe_n <= 1'b0;
          end
          D_READ: begin
            sda_oe_n <= 1'b1;
          end
          default: begin
            state <= D_IDLE;
          end
        endcase
      end else if (active && scl_fall) begin
        if (bit_cnt == BIT_DONE) begin
          bit_cnt <= 4'h0;
          if (state == D_READ && !mack) begin
            shreg    <= mem_q;
            ptr      <= ptr + 11'h001;
            sda_oe_n <= mem_q[BYTE_W-1];
          end else if (state == D_READ) begin
            state    <= D_IDLE;
            sda_oe_n <= 1'b1;
          end else begin
            sda_oe_n <= 1'b1;
          end
        end else if (state == D_READ) begin
          sda_oe_n <= shreg[BYTE_W-1];
        end
      end
    end
  end
endmodule

// >>> see_bus_master.sv
// two-wire bus master: byte/page writes and random or sequential reads
`timescale 1ns/1ps
module see_bus_master
  import see_pkg::*;
#(
  parameter int SCL_HZ = SCL_DEF_HZ
)
(
  // clock and reset
  input  wire logic              clk_in,
  input  wire logic              sys_rst_in,
  // command
  input  wire logic              cmd_valid_in,
  input  wire logic              cmd_read_in,
  input  wire logic [ADDR_W-1:0] cmd_addr_in,
  input  wire logic [PAGE_W:0]   cmd_len_in,
  output logic                   cmd_ready_out,
  // write data
  input  wire logic [BYTE_W-1:0] wr_data_in,
  output logic                   wr_take_out,
  // read data and completion
  output logic [BYTE_W-1:0]      rd_data_out,
  output logic                   rd_valid_out,
  output logic                   done_out,
  output logic                   nack_out,
  // two-wire bus
  see_link_if.master             bus
);
  // the rate is clamped so the bus never runs above its ceiling
  localparam int EFF_HZ  = (SCL_HZ > SCL_MAX_HZ) ? SCL_MAX_HZ : SCL_HZ;
  localparam int QTR_NS  = NS_PER_S / EFF_HZ / QUARTERS;
  localparam int QTR_CYC = (QTR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int QCNT_W  = $clog2(QTR_CYC + 1);

  typedef enum logic [1:0] {M_IDLE, M_START, M_BITS, M_STOP} see_mst_state_t;
  typedef enum logic [2:0] {K_CTRL, K_ADDR, K_WDATA, K_RCTRL, K_RDATA} see_byte_kind_t;

  see_mst_state_t    state;
  see_byte_kind_t    kind;
  logic [QCNT_W-1:0] qcnt;
  logic [1:0]        phase;
  logic [3:0]        bit_cnt;
  logic [BYTE_W-1:0] shreg;
  logic [ADDR_W-1:0] addr;
  logic              is_read;
  logic [PAGE_W:0]   left;
  logic              ack_bit;
  logic              err;
  logic              scl;
  logic              sda_oe_n;
  logic              sda_s1;
  logic              sda_s2;

  wire tick      = (state != M_IDLE) && (qcnt == '0);
  wire rx_byte   = (kind == K_RDATA);
  wire last_byte = (left == 5'h01);
  wire in_data   = (bit_cnt < BIT_ACK);
  wire [BYTE_W-1:0] ctrl_w = {CTRL_PATTERN, addr[ADDR_W-1:BYTE_W], RW_WRITE};
  wire [BYTE_W-1:0] ctrl_r = {CTRL_PATTERN, addr[ADDR_W-1:BYTE_W], RW_READ};

  // this end owns the clock and drives it push-pull; data is open drain
  assign bus.scl        = scl;
  assign bus.m_sda_o    = 1'b0;
  assign bus.m_sda_oe_n = sda_oe_n;

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
    end else begin
      sda_s1 <= bus.sda;
      sda_s2 <= sda_s1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      state         <= M_IDLE;
      kind          <= K_CTRL;
      qcnt          <= '0;
      phase         <= 2'h0;
      bit_cnt       <= 4'h0;
      shreg         <= 8'h00;
      addr          <= 11'h000;
      is_read       <= 1'b0;
      left          <= 5'h00;
      ack_bit       <= 1'b1;
      err           <= 1'b0;
      scl           <= 1'b1;
      sda_oe_n      <= 1'b1;
      cmd_ready_out <= 1'b1;
      wr_take_out   <= 1'b0;
      rd_data_out   <= 8'h00;
      rd_valid_out  <= 1'b0;
      done_out      <= 1'b0;
      nack_out      <= 1'b0;
    end else begin
      wr_take_out  <= 1'b0;
      rd_valid_out <= 1'b0;
      done_out     <= 1'b0;
      if (state != M_IDLE) begin
        qcnt <= (qcnt == '0) ? QCNT_W'(QTR_CYC - 1) : qcnt - 1'b1;
      end
      if (state == M_IDLE && cmd_valid_in) begin
        addr          <= cmd_addr_in;
        is_read       <= cmd_read_in;
        left          <= (cmd_len_in == 5'h00) ? 5'h01 : cmd_len_in;
        shreg         <= {CTRL_PATTERN, cmd_addr_in[ADDR_W-1:BYTE_W], RW_WRITE};
        kind          <= K_CTRL;
        err           <= 1'b0;
        state         <= M_START;
        phase         <= 2'h0;
        qcnt          <= QCNT_W'(QTR_CYC - 1);
        cmd_ready_out <= 1'b0;
      end else if (tick) begin
        phase <= phase + 2'h1;
        case (state)
          M_START: begin
            case (phase)
              2'h0: begin
                scl      <= 1'b0;
                sda_oe_n <= 1'b1;
              end
              2'h1: scl <= 1'b1;
              2'h2: sda_oe_n <= 1'b0;
              default: begin
                scl     <= 1'b0;
                bit_cnt <= 4'h0;
                state   <= M_BITS;
              end
            endcase
          end
          M_BITS: begin
            case (phase)
              2'h0: sda_oe_n <= in_data ? (rx_byte | shreg[BYTE_W-1]) : (~rx_byte | last_byte);
              2'h1: scl <= 1'b1;
              2'h2: begin
                if (in_data) begin
                  shreg <= {shreg[BYTE_W-2:0], sda_s2};
                end else begin
                  ack_bit <= sda_s2;
                end
              end
              default: begin
                scl <= 1'b0;
                if (in_data) begin
                  bit_cnt <= bit_cnt + 4'h1;
                end else begin
                  bit_cnt <= 4'h0;
                  if (rx_byte) begin
                    rd_data_out  <= shreg;
                    rd_valid_out <= 1'b1;
                    left         <= left - 5'h01;
                    if (last_byte) begin
                      state <= M_STOP;
                    end
                  end else if (ack_bit) begin
                    err   <= 1'b1;
                    state <= M_STOP;
                  end else begin
                    case (kind)
                      K_CTRL: begin
                        kind  <= K_ADDR;
                        shreg <= addr[BYTE_W-1:0];
                      end
                      K_ADDR: begin
                        if (is_read) begin
                          kind  <= K_RCTRL;
                          shreg <= ctrl_r;
                          state <= M_START;
                        end else begin
                          kind        <= K_WDATA;
                          shreg       <= wr_data_in;
                          wr_take_out <= 1'b1;
                        end
                      end
                      K_WDATA: begin
                        left <= left - 5'h01;
                        if (last_byte) begin
                          state <= M_STOP;
                        end else begin
                          shreg       <= wr_data_in;
                          wr_take_out <= 1'b1;
                        end
                      end
                      K_RCTRL: kind <= K_RDATA;
                      default: shreg <= ctrl_w;
                    endcase
                  end
                end
              end
            endcase
          end
          M_STOP: begin
            case (phase)
              2'h0: sda_oe_n <= 1'b0;
              2'h1: scl <= 1'b1;
              2'h2: sda_oe_n <= 1'b1;
              default: begin
                state         <= M_IDLE;
                done_out      <= 1'b1;
                nack_out      <= err;
                cmd_ready_out <= 1'b1;
              end
            endcase
          end
          default: state <= M_IDLE;
        endcase
      end
    end
  end
endmodule

// >>> see_link_monitor.sv
// checker for the two-wire link and the slave status
`timescale 1ns/1ps
module see_link_monitor
  import see_pkg::*;
#(
  parameter int WRITE_CYCLES = WRITE_CYC
)
(
  // clock and reset
  input wire logic link_clk_in,
  input wire logic sys_rst_in,
  // link
  input wire logic scl,
  input wire logic m_sda_o,
  input wire logic m_sda_oe_n,
  input wire logic d_sda_o,
  input wire logic d_sda_oe_n,
  input wire logic sda,
  // status
  input wire logic standby_out,
  input wire logic busy_out
);
  logic       scl_q;
  logic       sda_q;
  logic       first;
  logic [3:0] nbit;
  logic [7:0] shreg;
  int         bcnt;
  wire        rise  = scl && !scl_q;
  wire        start = scl && scl_q && sda_q && !sda;
  wire        stop  = scl && scl_q && !sda_q && sda;
  wire        ninth = rise && nbit == BIT_ACK;
  wire        good  = shreg[7:4] == CTRL_PATTERN;

  default clocking @(posedge link_clk_in); endclocking
  default disable iff (sys_rst_in);

  always_ff @(posedge link_clk_in) begin
    scl_q <= scl;
    sda_q <= sda;
    bcnt  <= busy_out ? bcnt + 1 : 0;
  end
  // raw wires are clean in simulation, so no filter is needed here
  always_ff @(posedge link_clk_in) begin
    if (sys_rst_in || start) begin
      nbit  <= 4'h0;
      first <= 1'b1;
    end else if (rise) begin
      nbit  <= ninth ? 4'h0 : nbit + 4'h1;
      first <= first && !ninth;
      shreg <= ninth ? shreg : {shreg[6:0], sda};
    end
  end

  drain_only_a: assert property (!d_sda_oe_n |-> !d_sda_o)
    else $error("slave drove the data line high");
  reset_idle_a: assert property (disable iff (1'b0)
    sys_rst_in |=> standby_out && !busy_out && d_sda_oe_n) else $error("slave not idle in reset");
  low_phase_a: assert property ($changed(d_sda_oe_n) |-> !scl)
    else $error("slave changed data while clock high");
  ctrl_ack_a: assert property (ninth && first && good && !busy_out |-> !d_sda_oe_n && m_sda_oe_n)
    else $error("control byte not acknowledged");
  busy_nack_a: assert property (ninth && first && busy_out |-> d_sda_oe_n)
    else $error("acknowledge while programming");
  busy_max_a: assert property (busy_out |-> bcnt <= WRITE_CYCLES)
    else $error("programming ran too long");
  busy_min_a: assert property ($rose(busy_out) |-> busy_out[*8])
    else $error("programming cut short");
  busy_excl_a: assert property (busy_out |-> !standby_out)
    else $error("standby while programming");
  standby_back_a: assert property ($fell(busy_out) |-> ##[0:3] standby_out)
    else $error("no standby after programming");
  stop_idle_a: assert property (stop && !busy_out |-> ##[1:12] (standby_out || busy_out))
    else $error("no standby after stop");

  cover property (ninth && first && busy_out);
  cover property ($fell(busy_out));
  cover property (stop && !busy_out);
endmodule

// >>> serial_eeprom_two_wire_slave_tb.sv
// bench: bus master drives the eeprom slave, an array model checks reads
`timescale 1ns/1ps
module serial_eeprom_two_wire_slave_tb
  import see_pkg::*;
;
  localparam int WCYC = 400;
  logic              clk_in       = 1'b0;
  logic              link_clk_in  = 1'b0;
  logic              sys_rst_in   = 1'b1;
  logic              cmd_valid_in = 1'b0;
  logic              cmd_read_in  = 1'b0;
  logic [ADDR_W-1:0] cmd_addr_in  = '0;
  logic [PAGE_W:0]   cmd_len_in   = '0;
  logic [BYTE_W-1:0] wr_data_in   = '0;
  logic              wp_in        = 1'b0;
  logic              strap_select_bit0_in = 1'b0;
  logic              strap_select_bit1_in = 1'b0;
  logic              strap_select_bit2_in = 1'b0;
  logic              cmd_ready_out;
  logic              wr_take_out;
  logic              rd_valid_out;
  logic              done_out;
  logic              nack_out;
  logic              standby_out;
  logic              busy_out;
  logic [BYTE_W-1:0] rd_data_out;
  logic [7:0]        wdat [16];
  logic [7:0]        mem [int];
  int                err_count = 0;
  int                n_tests   = 0;
  int                seed      = 32'h0f8cee70;
  int                widx      = 0;

  see_link_if link ();

  always #25 clk_in = ~clk_in;
  // offset start keeps the link clock's edges clear of clk_in's edges
  initial begin
    #7;
    forever #80 link_clk_in = ~link_clk_in;
  end

  see_bus_master see_bus_master_inst (
    .clk_in, .sys_rst_in, .cmd_valid_in, .cmd_read_in, .cmd_addr_in, .cmd_len_in,
    .cmd_ready_out, .wr_data_in, .wr_take_out, .rd_data_out, .rd_valid_out,
    .done_out, .nack_out, .bus(link.master));
  see_eeprom_dev #(.WRITE_CYCLES(WCYC)) see_eeprom_dev_inst (
    .link_clk_in, .sys_rst_in, .bus(link.device), .wp_in, .strap_select_bit0_in,
    .strap_select_bit1_in, .strap_select_bit2_in, .standby_out, .busy_out);
  see_link_monitor #(.WRITE_CYCLES(WCYC)) see_link_monitor_inst (
    .link_clk_in, .sys_rst_in, .scl(link.scl), .m_sda_o(link.m_sda_o),
    .m_sda_oe_n(link.m_sda_oe_n), .d_sda_o(link.d_sda_o),
    .d_sda_oe_n(link.d_sda_oe_n), .sda(link.sda), .standby_out, .busy_out);

  // next byte only after the master reports the previous one taken
  always @(negedge clk_in) begin
    if (wr_take_out) begin
      widx++;
      wr_data_in <= wdat[widx % 16];
    end
  end

  task automatic check(string what, logic [15:0] got, logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // one command, entered at a falling edge; reads compared with the model
  task automatic xfer(logic rd, logic [10:0] a, int len, logic nk);
    int          ri;
    int          k;
    logic [10:0] pa;
    ri = 0;
    widx = 0;
    wr_data_in <= wdat[0];
    cmd_read_in <= rd;
    cmd_addr_in <= a;
    cmd_len_in <= 5'(len);
    cmd_valid_in <= 1'b1;
    @(negedge clk_in) cmd_valid_in <= 1'b0;
    check("ready", 16'(cmd_ready_out), 16'h0);
    for (k = 0; k < 40000 && !done_out; k++) begin
      @(negedge clk_in);
      if (rd_valid_out) begin
        pa = a + 11'(ri);
        if (mem.exists(pa)) check("rd_data", 16'(rd_data_out), 16'(mem[pa]));
        ri++;
      end
    end
    // a hang lands here with done_out low and counts as a mismatch
    check("done", 16'(done_out), 16'h1);
    check("ready", 16'(cmd_ready_out), 16'h1);
    check("nack", 16'(nack_out), 16'(nk));
    if (!rd && !nk) check("takes", 16'(widx), 16'(len));
    if (rd) check("rd_count", 16'(ri), 16'(len));
    else if (!nk && !wp_in)
      for (int i = 0; i < len; i++) mem[{a[10:4], a[3:0] + 4'(i)}] = wdat[i];
  endtask

  task automatic settle(logic eb);
    int k;
    repeat (40) @(negedge clk_in);
    check("busy", 16'(busy_out), 16'(eb));
    for (k = 0; k < 5000 && busy_out; k++) @(negedge clk_in);
    repeat (8) @(negedge clk_in);
    check("standby", 16'(standby_out), 16'h1);
  endtask

  initial begin
    int          b;
    logic [10:0] a;
    repeat (8) @(negedge clk_in);
    sys_rst_in <= 1'b0;
    repeat (40) @(negedge clk_in);
    check("standby", 16'(standby_out), 16'h1);
    for (int i = 0; i < 16; i++) wdat[i] = 8'($random(seed));
    xfer(1'b0, 11'h7F0, 16, 1'b0);
    settle(1'b1);
    $display("test page_fill done");
    for (int i = 0; i < 16; i++) wdat[i] = 8'($random(seed));
    xfer(1'b0, 11'h7FE, 3, 1'b0);
    xfer(1'b0, 11'h7FE, 1, 1'b1);
    // the refused attempt leaves the earlier partial write still programming
    settle(1'b1);
    xfer(1'b1, 11'h7F0, 16, 1'b0);
    $display("test partial_wrap done");
    for (int i = 0; i < 16; i++) wdat[i] = 8'($random(seed));
    wp_in <= 1'b1;
    xfer(1'b0, 11'h7F3, 2, 1'b0);
    settle(1'b0);
    wp_in <= 1'b0;
    xfer(1'b1, 11'h7F3, 2, 1'b0);
    $display("test protect done");
    // straps change every pass; the slave must ignore them
    for (b = 0; b < 8; b++) begin
      {strap_select_bit2_in, strap_select_bit1_in, strap_select_bit0_in} <= 3'($random(seed));
      a = {3'(b), 8'($random(seed))};
      wdat[0] = 8'($random(seed));
      xfer(1'b0, a, 1, 1'b0);
      settle(1'b1);
      xfer(1'b1, a, 1, 1'b0);
    end
    $display("test blocks done");
    results();
  end

  initial begin
    repeat (130000) @(negedge clk_in);
    err_count++;
    results();
  end
endmodule
